// File: src/csrb_consts.vh
// Constants for the charger status register bank and its serial port
`ifndef CSRB_CONSTS_VH
`define CSRB_CONSTS_VH

// Register offsets on the serial port
`define CSRB_OFS_OPT_THERM  8'h1d
`define CSRB_OFS_FET_TMR    8'h1e
`define CSRB_OFS_TEMP_ZONE  8'h1f
`define CSRB_OFS_FAULT      8'h20

// Reset value of every status register
`define CSRB_RST_VAL        8'h00

// Optimizer and thermal register fields
`define CSRB_OPT_STATE_HI   7
`define CSRB_OPT_STATE_LO   6
`define CSRB_THERM_REG_BIT  2
`define CSRB_DL_BUSY_BIT    1
`define CSRB_BAT_PRES_BIT   0

// Blocking pair, conversion and timer register fields
`define CSRB_IN2_FET_BIT    7
`define CSRB_IN1_FET_BIT    6
`define CSRB_CONV_DONE_BIT  5
`define CSRB_MIN_SYS_BIT    4
`define CSRB_FAST_TMR_BIT   3
`define CSRB_TRKL_TMR_BIT   2
`define CSRB_PRE_TMR_BIT    1

// Temperature zone register fields
`define CSRB_BAT_LOW_BIT    4
`define CSRB_COLD_BIT       3
`define CSRB_COOL_BIT       2
`define CSRB_WARM_BIT       1
`define CSRB_HOT_BIT        0

// Serial port framing; the bus address value is arbitrary
`define CSRB_DEV_ADDR       7'h2a
`define CSRB_BITS_PER_BYTE  4'h8
`define CSRB_SYNC_WIDTH     29

`endif

// File: src/csrb_sync.v
// Two-flop synchroniser bank for asynchronous status and pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "csrb_consts.vh"

module csrb_sync (
  // Clock and reset
  input  wire                         core_clk_i,
  input  wire                         rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire [`CSRB_SYNC_WIDTH-1:0]  async_i,
  output wire [`CSRB_SYNC_WIDTH-1:0]  sync_o
);

  genvar g;

  // One pair of flops per bit; the first stage feeds only the second
  generate
    for (g = 0; g < `CSRB_SYNC_WIDTH; g = g + 1) begin : g_bit
      reg meta_r;
      reg stab_r;
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r <= 1'b0;
          stab_r <= 1'b0;
        end else begin
          meta_r <= async_i[g];
          stab_r <= meta_r;
        end
      end
      assign sync_o[g] = stab_r;
    end
  endgenerate

endmodule
`default_nettype wire

// File: src/csrb_status_bank.v
// Charger status register bank read by a host over a two-wire serial port
`timescale 1ns/1ps
`default_nettype none
`include "csrb_consts.vh"

module csrb_status_bank (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  // Serial port pins; the data pin is open drain
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  // Optimizer, thermal and detection status from the analog side
  input  wire [1:0] current_optimizer_state_i,
  input  wire       die_thermal_regulation_i,
  input  wire       data_line_detection_busy_i,
  input  wire       battery_present_i,
  // Blocking pairs, conversion and regulation status
  input  wire       input2_blocking_fets_fitted_i,
  input  wire       input1_blocking_fets_fitted_i,
  input  wire       conversion_done_i,
  input  wire       one_shot_mode_i,
  input  wire       min_system_regulation_i,
  input  wire       forward_mode_i,
  // Safety timers
  input  wire       fast_timer_expired_i,
  input  wire       trickle_timer_expired_i,
  input  wire       precharge_timer_expired_i,
  // Output permission and thermistor zones
  input  wire       battery_low_for_output_i,
  input  wire       thermistor_cold_zone_i,
  input  wire       thermistor_cool_zone_i,
  input  wire       thermistor_warm_zone_i,
  input  wire       thermistor_hot_zone_i,
  // Protection conditions, bit 7 down to bit 0
  input  wire [7:0] protection_fault_i
);

  // Serial engine states. Idle waits for a start, address takes the
  // first byte, acknowledge holds the line low for the ninth bit,
  // receive takes the pointer and any data bytes, transmit shifts a
  // register byte out and host-acknowledge decides whether to go on.
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_RX   = 3'h3;
  localparam [2:0] ST_TX   = 3'h4;
  localparam [2:0] ST_MACK = 3'h5;

  // Raw and synchronised input vectors
  wire [`CSRB_SYNC_WIDTH-1:0] raw_w;
  wire [`CSRB_SYNC_WIDTH-1:0] syn_w;

  // Register map, all read-only:
  //   1d  optimizer state [7:6], thermal regulation [2],
  //       detection busy [1], battery present [0]
  //   1e  input 2 pair [7], input 1 pair [6], conversion done [5],
  //       minimum system [4], fast [3], trickle [2], precharge [1]
  //   1f  battery low for output [4], cold [3], cool [2], warm [1],
  //       hot [0]
  //   20  protection conditions, one flag per bit
  //   Every other offset and every unlisted bit reads zero.

  reg  [7:0] opt_therm_r;
  reg  [7:0] fet_tmr_r;
  reg  [7:0] temp_zone_r;
  reg  [7:0] fault_r;
  reg  [7:0] opt_therm_nxt;
  reg  [7:0] fet_tmr_nxt;
  reg  [7:0] temp_zone_nxt;

  // Serial engine state
  reg        scl_d_r;
  reg        sda_d_r;
  reg  [2:0] state_r;
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] ptr_r;
  reg        rw_r;
  reg        ptr_done_r;
  reg        nack_r;
  reg        oe_r;
  reg  [7:0] rd_data;

  // Synchronised pins and the bus events derived from them
  wire       scl_s;
  wire       sda_s;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_seen;
  wire       stop_seen;
  wire       byte_done;

  // Every status level and both pins arrive from another domain.
  // The pins go in inverted so that the synchroniser's zero reset
  // reads as an idle high bus; otherwise a false clock fall and a
  // false data edge would follow every reset.
  assign raw_w = {~scl_i, ~sda_i,
                  current_optimizer_state_i,
                  die_thermal_regulation_i,
                  data_line_detection_busy_i,
                  battery_present_i,
                  input2_blocking_fets_fitted_i,
                  input1_blocking_fets_fitted_i,
                  conversion_done_i,
                  one_shot_mode_i,
                  min_system_regulation_i,
                  forward_mode_i,
                  fast_timer_expired_i,
                  trickle_timer_expired_i,
                  precharge_timer_expired_i,
                  battery_low_for_output_i,
                  thermistor_cold_zone_i,
                  thermistor_cool_zone_i,
                  thermistor_warm_zone_i,
                  thermistor_hot_zone_i,
                  protection_fault_i};

  // One bank for every input keeps their latencies equal
  csrb_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (raw_w),
    .sync_o     (syn_w)
  );

  // Undo the inversion on the pin bits
  assign scl_s = ~syn_w[28];
  assign sda_s = ~syn_w[27];

  // Assemble the register images; reserved positions stay zero
  always @* begin
    opt_therm_nxt = `CSRB_RST_VAL;
    fet_tmr_nxt   = `CSRB_RST_VAL;
    temp_zone_nxt = `CSRB_RST_VAL;
    // Reserved optimizer code 3 is passed through as reported
    opt_therm_nxt[`CSRB_OPT_STATE_HI:`CSRB_OPT_STATE_LO] =
      syn_w[26:25];
    opt_therm_nxt[`CSRB_THERM_REG_BIT] = syn_w[24];
    opt_therm_nxt[`CSRB_DL_BUSY_BIT]   = syn_w[23];
    opt_therm_nxt[`CSRB_BAT_PRES_BIT]  = syn_w[22];
    fet_tmr_nxt[`CSRB_IN2_FET_BIT]     = syn_w[21];
    fet_tmr_nxt[`CSRB_IN1_FET_BIT]     = syn_w[20];
    // Done only means something when conversions are one-shot
    fet_tmr_nxt[`CSRB_CONV_DONE_BIT]   = syn_w[19] & syn_w[18];
    // Minimum system regulation is a forward-mode indication only
    fet_tmr_nxt[`CSRB_MIN_SYS_BIT]     = syn_w[17] & syn_w[16];
    fet_tmr_nxt[`CSRB_FAST_TMR_BIT]    = syn_w[15];
    fet_tmr_nxt[`CSRB_TRKL_TMR_BIT]    = syn_w[14];
    fet_tmr_nxt[`CSRB_PRE_TMR_BIT]     = syn_w[13];
    temp_zone_nxt[`CSRB_BAT_LOW_BIT]   = syn_w[12];
    temp_zone_nxt[`CSRB_COLD_BIT]      = syn_w[11];
    temp_zone_nxt[`CSRB_COOL_BIT]      = syn_w[10];
    temp_zone_nxt[`CSRB_WARM_BIT]      = syn_w[9];
    temp_zone_nxt[`CSRB_HOT_BIT]       = syn_w[8];
  end

  // Status registers track live levels; no bus path writes them.
  // A level shows three clocks after it changes (two sync flops and
  // this image); a condition that clears before the host reads is not
  // held, because these bits are status, not flags.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_therm_r <= `CSRB_RST_VAL;
      fet_tmr_r   <= `CSRB_RST_VAL;
      temp_zone_r <= `CSRB_RST_VAL;
      fault_r     <= `CSRB_RST_VAL;
    end else begin
      opt_therm_r <= opt_therm_nxt;
      fet_tmr_r   <= fet_tmr_nxt;
      temp_zone_r <= temp_zone_nxt;
      fault_r     <= syn_w[7:0];
    end
  end

  // Read decode; unmapped offsets answer zero. The pointer wraps at
  // ff, so a long burst comes back round to the mapped offsets.
  always @* begin
    if (ptr_r == `CSRB_OFS_OPT_THERM) begin
      rd_data = opt_therm_r;
    end else if (ptr_r == `CSRB_OFS_FET_TMR) begin
      rd_data = fet_tmr_r;
    end else if (ptr_r == `CSRB_OFS_TEMP_ZONE) begin
      rd_data = temp_zone_r;
    end else if (ptr_r == `CSRB_OFS_FAULT) begin
      rd_data = fault_r;
    end else begin
      rd_data = `CSRB_RST_VAL;
    end
  end

  // Pin edge and bus condition detection on synchronised pins.
  // Start and stop compare two samples, so a data change that lands
  // in the same clock as a clock-pin change is not seen as either.
  assign scl_rise   = scl_s & ~scl_d_r;
  assign scl_fall   = ~scl_s & scl_d_r;
  assign start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_seen  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign byte_done  = (bit_cnt_r == `CSRB_BITS_PER_BYTE);

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Serial engine: sample on the clock rise, change drive on the fall.
  // No clock stretching, so the host sets the pace of every byte.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      // With no pointer written yet, a bare read starts at offset 00
      ptr_r      <= 8'h00;
      rw_r       <= 1'b0;
      ptr_done_r <= 1'b0;
      nack_r     <= 1'b0;
      oe_r       <= 1'b0;
    end else if (start_seen) begin
      // A repeated start keeps the pointer so a read can follow it
      state_r    <= ST_ADDR;
      bit_cnt_r  <= 4'h0;
      ptr_done_r <= 1'b0;
      oe_r       <= 1'b0;
    end else if (stop_seen) begin
      state_r <= ST_IDLE;
      oe_r    <= 1'b0;
    end else begin
      case (state_r)
        // Sample on each rise; act on the fall after the eighth bit
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == `CSRB_DEV_ADDR) begin
                rw_r    <= shift_r[0];
                state_r <= ST_ACK;
                oe_r    <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
            end else begin
              // First byte sets the pointer; data bytes are dropped
              if (!ptr_done_r) begin
                ptr_r      <= shift_r;
                ptr_done_r <= 1'b1;
              end
              state_r <= ST_ACK;
              oe_r    <= 1'b1;
            end
          end
        end
        // Hold the line low until the ninth clock falls
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              shift_r <= rd_data;
              oe_r    <= ~rd_data[7];
              ptr_r   <= ptr_r + 8'h01;
              state_r <= ST_TX;
            end else begin
              oe_r    <= 1'b0;
              state_r <= ST_RX;
            end
          end
        end
        // Bits leave MSB first, each one changed on a clock fall
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              oe_r    <= 1'b0;
              nack_r  <= 1'b0;
              state_r <= ST_MACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              oe_r    <= ~shift_r[6];
            end
          end
        end
        // A released line on the ninth bit ends the read
        ST_MACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= ST_IDLE;
            end else begin
              // Auto-increment walks on through the map
              shift_r <= rd_data;
              oe_r    <= ~rd_data[7];
              ptr_r   <= ptr_r + 8'h01;
              state_r <= ST_TX;
            end
          end
        end
        // Idle and any stray code wait for a start
        default: begin
          state_r <= ST_IDLE;
          oe_r    <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pull low; the board's pull-up makes the high
  // level, so a released line never fights the host.
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_r;

endmodule
`default_nettype wire

// File: testbench/csrb_status_bank_chk.sv
// Checker for the serial pin behaviour of the status register bank
`timescale 1ns/1ps
`default_nettype none
module csrb_status_bank_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Open drain: the pin may only ever be pulled low
  sda_value_a: assert property (sda_o == 1'b0)
    else $error("data pin value is not the open drain low");
  // Reset must leave the bus free, so no disable here
  reset_quiet_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
    !rst_n_i |-> !sda_oe_o) else $error("data pin driven in reset");
  boot_quiet_a: assert property ($rose(rst_n_i) |-> !sda_oe_o [*3])
    else $error("data pin driven just after reset");
  // Drive changes only with the clock pin low, else it reads as start/stop
  oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  oe_hold_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive not held over clock high");
  oe_latency_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i) &&
    ($past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5)))
    else $error("data drive changed away from a clock fall");
  start_release_a: assert property (scl_i && $fell(sda_i) |-> !sda_oe_o)
    else $error("device drives during a start");
  stop_release_a: assert property (scl_i && $rose(sda_i) |=> !sda_oe_o [*4])
    else $error("device drives after a stop");
endmodule

bind csrb_status_bank csrb_status_bank_chk chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

// File: testbench/csrb_host_model.sv
// Host model that reads and writes the status bank over the serial pins
`timescale 1ns/1ps
`default_nettype none
`include "csrb_consts.vh"
module csrb_host_model (
  // Clock
  input  wire logic core_clk_i,
  // Serial pins; the data line is only ever pulled low
  output var  logic scl_o,
  output var  logic sda_pull_o,
  input  wire logic sda_i
);
  localparam int HALF = 6; // Clocks per phase, above the four needed

  // Idle bus at time zero
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic phase();
    repeat (HALF) @(negedge core_clk_i);
  endtask

  // Data moves two clocks after the clock fall, so the synchronised
  // pins never see both change together and mistake it for a stop
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge core_clk_i);
    sda_pull_o = !b;
    phase();
    scl_o = 1'b1;
    phase();
    r = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask

  // Start, also used as repeated start with the clock low
  task automatic start();
    repeat (2) @(negedge core_clk_i);
    sda_pull_o = 1'b0;
    phase();
    scl_o = 1'b1;
    phase();
    sda_pull_o = 1'b1;
    phase();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(negedge core_clk_i);
    sda_pull_o = 1'b1;
    phase();
    scl_o = 1'b1;
    phase();
    sda_pull_o = 1'b0;
    phase();
  endtask

  // Pointer write, repeated start, n bytes back, last one refused
  task automatic read(input logic [7:0] ofs, input int n,
                      output logic [31:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({`CSRB_DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ofs, 1'b1, rx, a1);
    start();
    xfer({`CSRB_DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    ok = !(a0 || a1 || a2);
    d = '0;
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, rx, a0);
      d = {d[23:0], rx};
    end
    stop();
  endtask

  task automatic write(input logic [7:0] ofs, input logic [7:0] v,
                       output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({`CSRB_DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(ofs, 1'b1, rx, a1);
    xfer(v, 1'b1, rx, a2);
    ok = !(a0 || a1 || a2);
    stop();
  endtask
endmodule
`default_nettype wire

// File: testbench/csrb_status_bank_tb.sv
// Self-checking bench for the charger status register bank
`timescale 1ns/1ps
`default_nettype none
`include "csrb_consts.vh"
module csrb_status_bank_tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [26:0] st = '0;
  logic scl, pull, sda_o, sda_oe_o, sda_w;
  logic [1:0] opt;
  logic therm, dl, bat, in2, in1, done, os, ms, fwd, fast, trkl, pre;
  logic batlow, cold, cool, warm, hot;
  logic [7:0] fault;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #4 core_clk_i = ~core_clk_i;
  // Status levels come from one vector so a walking one reaches each
  assign {opt, therm, dl, bat, in2, in1, done, os, ms, fwd, fast, trkl,
          pre, batlow, cold, cool, warm, hot, fault} = st;
  // Wire is low whenever either side pulls
  assign sda_w = !(pull || (sda_oe_o && !sda_o));

  csrb_status_bank uut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .current_optimizer_state_i(opt), .die_thermal_regulation_i(therm),
    .data_line_detection_busy_i(dl), .battery_present_i(bat),
    .input2_blocking_fets_fitted_i(in2),
    .input1_blocking_fets_fitted_i(in1), .conversion_done_i(done),
    .one_shot_mode_i(os), .min_system_regulation_i(ms),
    .forward_mode_i(fwd), .fast_timer_expired_i(fast),
    .trickle_timer_expired_i(trkl), .precharge_timer_expired_i(pre),
    .battery_low_for_output_i(batlow), .thermistor_cold_zone_i(cold),
    .thermistor_cool_zone_i(cool), .thermistor_warm_zone_i(warm),
    .thermistor_hot_zone_i(hot), .protection_fault_i(fault));

  csrb_host_model host (
    .core_clk_i(core_clk_i), .scl_o(scl), .sda_pull_o(pull),
    .sda_i(sda_w));

  // Expected bytes 1d..20; gated bits need their mode, reserved read zero
  function automatic logic [31:0] expect_regs(input logic [26:0] s);
    return {s[26:25], 3'b000, s[24:22], s[21:20], s[19] & s[18],
            s[17] & s[16], s[15:13], 1'b0, 3'b000, s[12:8], s[7:0]};
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reads all four registers in one burst and compares each byte
  task automatic read_all();
    logic [31:0] d, e;
    logic ok;
    e = expect_regs(st);
    host.read(`CSRB_OFS_OPT_THERM, 4, d, ok);
    check("ack", {7'h00, ok}, 8'h01);
    check("opt_therm", d[31:24], e[31:24]);
    check("fet_tmr", d[23:16], e[23:16]);
    check("temp_zone", d[15:8], e[15:8]);
    check("fault", d[7:0], e[7:0]);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cut a hang short well past the expected 30k cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    logic [31:0] d;
    logic ok;
    repeat (6) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    read_all();
    $display("test reset values done");
    for (int i = 0; i < 27; i++) begin
      st = 27'h1 << i;
      read_all();
    end
    $display("test walking status bits done");
    st = '1;
    read_all();
    host.write(`CSRB_OFS_OPT_THERM, 8'h00, ok);
    check("write_ack", {7'h00, ok}, 8'h01);
    host.write(`CSRB_OFS_FAULT, 8'h00, ok);
    check("write_ack", {7'h00, ok}, 8'h01);
    read_all();
    host.read(`CSRB_OFS_FAULT, 2, d, ok);
    check("burst_ack", {7'h00, ok}, 8'h01);
    check("fault_burst", d[15:8], 8'hff);
    check("unmapped", d[7:0], 8'h00);
    $display("test writes and unmapped done");
    summarize();
  end
endmodule
`default_nettype wire
